// File: core/usr_core.sv
// USART receiver with two-frame buffer, synchronous clocking and host SPI.
`timescale 1ns/1ps
`default_nettype none
module usr_core #(
    parameter int BAUD_W = 16
) (
    input wire logic clock,
    input wire logic nrst,
    input wire logic link_clock,
    input wire logic rx_pin,
    input wire logic rx_enable,
    input wire logic [1:0] mode_sel,
    input wire logic [1:0] rx_mode,
    input wire logic [2:0] char_size_field,
    input wire logic [1:0] parity_mode,
    input wire logic bit_order_bit,
    input wire logic clock_phase_bit,
    input wire logic pin_invert_bit,
    input wire logic pin_direction_bit,
    input wire logic [BAUD_W-1:0] baud_div,
    input wire logic [7:0] spi_tx_data,
    input wire logic spi_tx_valid,
    input wire logic rd_high,
    input wire logic rd_low,
    output logic spi_tx_ready,
    output logic tx_pin,
    output logic tx_oe,
    output logic xck_out,
    output logic xck_oe,
    output logic [7:0] rx_high_byte_reg,
    output logic [7:0] rx_low_byte_reg,
    output logic rx_complete_flag
);
    localparam int BI_W = BAUD_W - usr_pkg::BAUD_INT_LSB;
    if (BAUD_W < usr_pkg::BAUD_INT_LSB + 2) begin : g_chk
        $error("BAUD_W too narrow for the integer divisor");
    end

    function automatic logic [7:0] rev8(input logic [7:0] v);
        for (int i = 0; i < 8; i++) begin
            rev8[i] = v[7-i];
        end
    endfunction

    // ==========================================================
    // Mode decode
    wire is_async = rx_enable && mode_sel == usr_pkg::MODE_ASYNC;
    wire is_sync = rx_enable && mode_sel == usr_pkg::MODE_SYNC;
    wire is_spi = rx_enable && mode_sel == usr_pkg::MODE_SPI;
    wire sync_host = is_sync && pin_direction_bit; // [R8]
    wire sync_client = is_sync && !pin_direction_bit; // [R8]
    wire nine_low = char_size_field == usr_pkg::CS_9L && !is_spi;
    wire nine_bit = char_size_field == usr_pkg::CS_9L || char_size_field == usr_pkg::CS_9H;
    wire par_on = parity_mode == usr_pkg::PAR_EVEN || parity_mode == usr_pkg::PAR_ODD;
    wire par_odd = parity_mode == usr_pkg::PAR_ODD;
    wire [3:0] nbits = nine_bit ? usr_pkg::CS_NINE : usr_pkg::CS_BASE + {1'b0, char_size_field};
    wire [BI_W-1:0] baud_int = baud_div[BAUD_W-1:usr_pkg::BAUD_INT_LSB];

    // ==========================================================
    // Link clock domain: client mode capture on both pin edges
    // Each edge keeps its own bit and toggle; the main domain picks one.
    logic [1:0] lrst_q;
    logic pos_bit, pos_tgl, neg_bit, neg_tgl;
    always_ff @(posedge link_clock) begin
        lrst_q <= {lrst_q[0], nrst};
    end
    always_ff @(posedge link_clock) begin
        if (!lrst_q[1]) begin
            pos_bit <= 1'b1;
            pos_tgl <= 1'b0;
        end else begin
            pos_bit <= rx_pin;
            pos_tgl <= ~pos_tgl;
        end
    end
    always_ff @(negedge link_clock) begin
        if (!lrst_q[1]) begin
            neg_bit <= 1'b1;
            neg_tgl <= 1'b0;
        end else begin
            neg_bit <= rx_pin;
            neg_tgl <= ~neg_tgl;
        end
    end

    // ==========================================================
    // Synchronisers
    // The toggle chain is two stages deeper than the bit chain, so the bit
    // has settled when its edge is seen; this leans on a slow client clock.
    logic [1:0] rx_q, pb_q, nb_q;
    logic [3:0] pt_q, nt_q;
    always_ff @(posedge clock) begin
        if (!nrst) begin
            rx_q <= '1;
            pb_q <= '1;
            nb_q <= '1;
            pt_q <= '0;
            nt_q <= '0;
        end else begin
            rx_q <= {rx_q[0], rx_pin};
            pb_q <= {pb_q[0], pos_bit};
            nb_q <= {nb_q[0], neg_bit};
            pt_q <= {pt_q[2:0], pos_tgl}; // [R13]
            nt_q <= {nt_q[2:0], neg_tgl}; // [R13]
        end
    end
    wire rx_s = rx_q[1];
    wire c_edge = pin_invert_bit ? pt_q[3] ^ pt_q[2] : nt_q[3] ^ nt_q[2]; // [R10] [R11]
    wire c_bit = pin_invert_bit ? pb_q[1] : nb_q[1]; // [R11]

    // ==========================================================
    // Rate divisor tick, shared by async sampling and clock generation
    logic [BI_W-1:0] hcnt;
    logic sck, spi_busy;
    wire spi_start = is_spi && spi_tx_valid && !spi_busy;
    wire tick = ({1'b0, hcnt} + 1'b1) >= {1'b0, baud_int};
    always_ff @(posedge clock) begin
        if (!nrst || tick || spi_start) begin
            hcnt <= '0;
        end else begin
            hcnt <= hcnt + 1'b1;
        end
    end

    // ==========================================================
    // Async sampler with three-sample majority vote
    usr_pkg::usr_asm_e asm;
    logic a_act, abit_v, abit;
    logic [4:0] scnt;
    logic [1:0] votes;
    wire [4:0] sps = rx_mode == usr_pkg::RXM_DOUBLE ? usr_pkg::SPS_DBL : usr_pkg::SPS_NORM; // [R7]
    wire [4:0] vfirst = rx_mode == usr_pkg::RXM_DOUBLE ? usr_pkg::VOTE_DBL : usr_pkg::VOTE_NORM; // [R7]
    wire a_vote_end = a_act && tick && scnt == vfirst + usr_pkg::VOTE_SPAN;
    wire a_maj = (votes[0] & votes[1]) | (votes[0] & rx_s) | (votes[1] & rx_s);
    wire a_stop = (asm == usr_pkg::ASM_IDLE && a_maj) || asm == usr_pkg::ASM_STOP;
    always_ff @(posedge clock) begin
        if (!nrst || !is_async) begin
            a_act <= 1'b0;
            scnt <= '0;
            votes <= '0;
            abit_v <= 1'b0;
            abit <= 1'b1;
        end else begin
            abit_v <= a_vote_end;
            abit <= a_maj;
            if (tick && !a_act) begin
                a_act <= !rx_s;
                scnt <= 5'h01;
            end else if (tick) begin
                scnt <= scnt == sps ? 5'h01 : scnt + 5'h01;
                if (scnt == vfirst) votes[0] <= rx_s;
                if (scnt == vfirst + 5'h01) votes[1] <= rx_s;
                if (a_vote_end && a_stop) a_act <= 1'b0;
            end
        end
    end

    // ==========================================================
    // Frame assembler: start, data LSB first, parity, first stop bit
    wire bit_v = is_async ? abit_v : sync_host ? tick && sck : sync_client && c_edge; // [R12]
    wire bit_val = is_async ? abit : sync_client ? c_bit : rx_s;
    logic [3:0] bcnt;
    logic [8:0] sh;
    logic par, parity_error_flag;
    wire fr_done = bit_v && asm == usr_pkg::ASM_STOP;
    always_ff @(posedge clock) begin
        if (!nrst || !rx_enable || is_spi) begin
            asm <= usr_pkg::ASM_IDLE; // [R5]
            bcnt <= '0;
            sh <= '0;
            par <= 1'b0;
            parity_error_flag <= 1'b0;
        end else if (bit_v) begin
            unique case (asm)
                usr_pkg::ASM_IDLE: begin
                    if (!bit_val) asm <= usr_pkg::ASM_DATA;
                    bcnt <= '0;
                    sh <= '0;
                    par <= 1'b0;
                    parity_error_flag <= 1'b0;
                end
                usr_pkg::ASM_DATA: begin
                    sh[bcnt] <= bit_val;
                    par <= par ^ bit_val;
                    bcnt <= bcnt + 4'h1;
                    if (bcnt == nbits - 4'h1) asm <= par_on ? usr_pkg::ASM_PAR : usr_pkg::ASM_STOP;
                end
                usr_pkg::ASM_PAR: begin
                    parity_error_flag <= par ^ bit_val ^ par_odd; // [R2]
                    asm <= usr_pkg::ASM_STOP;
                end
                usr_pkg::ASM_STOP: asm <= usr_pkg::ASM_IDLE;
            endcase
        end
    end

    // ==========================================================
    // Host SPI engine
    // Nothing detects a transmit write during a frame: the ready output is
    // the only guard, and there is no select pin or multi-host arbitration.
    logic [4:0] hc;
    logic [7:0] tsr, rsr;
    logic spi_done;
    logic [3:0] shifts_seen;
    wire lead = !hc[0];
    wire s_evt = spi_busy && tick && (clock_phase_bit ? !lead : lead); // [R18]
    wire t_evt = spi_busy && tick && (clock_phase_bit ? lead && hc != '0 : !lead && hc != usr_pkg::SPI_LAST); // [R18]
    wire spi_end = spi_busy && tick && hc == usr_pkg::SPI_LAST; // [R14]
    assign spi_tx_ready = is_spi && !spi_busy; // [R20]
    always_ff @(posedge clock) begin
        if (!nrst || !is_spi) begin
            spi_busy <= 1'b0;
            hc <= '0;
            tsr <= '1;
            rsr <= '0;
            spi_done <= 1'b0;
            shifts_seen <= '0;
        end else begin
            spi_done <= spi_end;
            if (spi_start) begin
                spi_busy <= 1'b1;
                hc <= '0;
                shifts_seen <= '0;
                tsr <= bit_order_bit ? rev8(spi_tx_data) : spi_tx_data; // [R15]
            end else if (spi_busy && tick) begin
                hc <= hc + 5'h01;
                if (spi_end) spi_busy <= 1'b0;
            end
            if (t_evt) begin
                tsr <= {tsr[6:0], 1'b1}; // [R17]
                shifts_seen <= shifts_seen + 4'h1;
            end
            if (s_evt) rsr <= {rsr[6:0], rx_s}; // [R17]
        end
    end
    // Continuous clock in synchronous host mode; framed clock in SPI mode.
    always_ff @(posedge clock) begin
        if (!nrst || !(sync_host || spi_busy)) begin
            sck <= 1'b0;
        end else if (tick) begin
            sck <= ~sck; // [R16]
        end
    end
    assign xck_out = sck ^ pin_invert_bit; // [R11] [R18]
    assign xck_oe = sync_host || is_spi; // [R8] [R21]
    assign tx_pin = is_spi ? tsr[7] : 1'b1; // [R21]
    assign tx_oe = is_spi; // [R21]

    // ==========================================================
    // Two-frame receive buffer
    usr_pkg::usr_frame_s ent0, ent1, in_f, next_e0, next_e1;
    logic [1:0] cnt, next_cnt;
    wire push = fr_done || spi_done;
    wire [7:0] spi_rx = bit_order_bit ? rev8(rsr) : rsr; // [R15]
    wire shift_rd = nine_low ? rd_high : rd_low; // [R3] [R4]
    wire pop = shift_rd && cnt != 2'h0;
    assign in_f = spi_done ? {3'h0, 1'b0, spi_rx} : {!bit_val, 1'b0, parity_error_flag, sh}; // [R1] [R22]
    always_comb begin
        next_cnt = cnt;
        next_e0 = ent0;
        next_e1 = ent1;
        if (pop) begin
            next_e0 = ent1; // [R25]
            next_cnt = cnt - 2'h1;
        end
        if (push && next_cnt == 2'h2) begin
            next_e1 = in_f;
            next_e1.overrun = 1'b1; // [R23]
        end else if (push && next_cnt == 2'h1) begin
            next_e1 = in_f; // [R24]
            next_cnt = 2'h2;
        end else if (push) begin
            next_e0 = in_f;
            next_cnt = 2'h1;
        end
    end
    always_ff @(posedge clock) begin
        if (!nrst || !rx_enable) begin
            cnt <= '0; // [R5]
            ent0 <= '0;
            ent1 <= '0;
        end else begin
            cnt <= next_cnt;
            ent0 <= next_e0;
            ent1 <= next_e1;
        end
    end
    always_comb begin
        rx_high_byte_reg = '0;
        rx_high_byte_reg[usr_pkg::HI_RXC] = cnt != 2'h0; // [R25]
        rx_high_byte_reg[usr_pkg::HI_OVF] = ent0.overrun && !is_spi; // [R19]
        rx_high_byte_reg[usr_pkg::HI_FRAME_ERROR_FLAG] = ent0.frame_err && !is_spi; // [R19]
        rx_high_byte_reg[usr_pkg::HI_PARITY_ERROR_FLAG] = ent0.parity_err && !is_spi; // [R19]
        rx_high_byte_reg[usr_pkg::HI_D8] = ent0.data[8];
    end
    assign rx_low_byte_reg = ent0.data[7:0]; // [R24]
    assign rx_complete_flag = cnt != 2'h0;

    // ==========================================================
    // Checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);
    sequence spi_go;
        spi_start ##1 spi_busy;
    endsequence
    flush_empty_a: assert property (!rx_enable |=> !rx_complete_flag) else $error("buffer not flushed"); // [R5]
    low_shift_a: assert property (rx_enable && rd_low && !nine_low && cnt == 2'h1 && !push |=> cnt == 2'h0) // [R3]
        else $error("low read did not shift");
    high_shift_a: assert property (rx_enable && rd_high && nine_low && cnt == 2'h1 && !push |=> cnt == 2'h0) // [R4]
        else $error("high read did not shift");
    read_hold_a: assert property (rx_enable && $past(rx_enable) && !shift_rd && !push |=> cnt == $past(cnt)) // [R3]
        else $error("non-shifting read moved buffer");
    overrun_set_a: assert property (rx_enable && push && cnt == 2'h2 && !pop |=> ent1.overrun) // [R23]
        else $error("overrun not flagged");
    frame_error_flag_show_a: assert property (fr_done && !bit_val && cnt == 2'h0 |=> rx_high_byte_reg[usr_pkg::HI_FRAME_ERROR_FLAG]) // [R22]
        else $error("frame error not shown");
    spi_clean_a: assert property (is_spi && spi_done |=> rx_complete_flag // [R19]
        && rx_high_byte_reg[usr_pkg::HI_FRAME_ERROR_FLAG:usr_pkg::HI_PARITY_ERROR_FLAG] == 2'h0 && !rx_high_byte_reg[usr_pkg::HI_OVF])
        else $error("SPI frame error flags set");
    spi_bits_a: assert property (spi_end |-> shifts_seen == usr_pkg::SPI_SHIFTS) // [R14]
        else $error("SPI frame not eight bits");
    spi_idle_a: assert property (spi_go |-> xck_out == pin_invert_bit) // [R18]
        else $error("SPI clock not idle at start");
    mosi_hold_a: assert property (is_spi && $past(is_spi) && $changed(tx_pin) // [R17]
        |-> $past(t_evt) || $past(spi_start))
        else $error("host-out changed off its edge");
    rxc_cause_a: assert property (rx_enable && $rose(rx_complete_flag) |-> $past(push)) // [R25]
        else $error("receive complete without frame");
endmodule
`default_nettype wire

// File: core/usr_pkg.sv
// Constants and types shared by the USART receive and host SPI block.
// Behaviour
// R1: Each stored frame keeps frame, overrun, parity flags.
// R2: Compute parity, flag mismatch with received parity bit.
// R3: Low byte read shifts buffer, except low-first.
// R4: In low-first nine-bit mode, high byte shifts.
// R5: Receiver disable flushes buffer and drops frame at once.
// R6: Software flushes by reading until receive complete clears.
// R7: Async normal takes 16 samples, double speed eight.
// R8: Clock pin direction picks host or client role.
// R9: Software sets clock pin direction before synchronous traffic.
// R10: Sample on edge opposite the data change edge.
// R11: Invert off: rise starts bit, fall samples.
// R12: Client mode ignores divisor, follows external clock.
// R13: External client clock stays below quarter peripheral clock.
// R14: Host SPI frame is exactly eight data bits.
// R15: Bit order bit selects LSB or MSB first.
// R16: Host SPI drives serial clock from rate generator.
// R17: Each bit held one period, sampled mid-period.
// R18: Phase picks sample edge, invert picks leading polarity.
// R19: Host SPI error flags always read zero.
// R20: No collision guard, double speed, or multi-host.
// R21: Transmit pin host-out, receive host-in, no select.
// R22: First stop bit low sets frame error.
// R23: Frame arriving at full buffer sets overrun.
// R24: Buffer holds two frames, presents the oldest.
// R25: Shift presents next frame, clears complete when empty.
package usr_pkg;
    localparam logic [1:0] MODE_ASYNC = 2'h0;
    localparam logic [1:0] MODE_SYNC = 2'h1;
    localparam logic [1:0] MODE_SPI = 2'h3;
    localparam logic [1:0] RXM_DOUBLE = 2'h1;
    localparam logic [2:0] CS_9L = 3'h6;
    localparam logic [2:0] CS_9H = 3'h7;
    localparam logic [3:0] CS_BASE = 4'h5;
    localparam logic [3:0] CS_NINE = 4'h9;
    localparam logic [1:0] PAR_EVEN = 2'h2;
    localparam logic [1:0] PAR_ODD = 2'h3;
    localparam logic [4:0] SPS_NORM = 5'h10;
    localparam logic [4:0] SPS_DBL = 5'h08;
    localparam logic [4:0] VOTE_NORM = 5'h08;
    localparam logic [4:0] VOTE_DBL = 5'h04;
    localparam logic [4:0] VOTE_SPAN = 5'h02;
    // Sixteen half periods make the eight bits of one SPI frame.
    localparam logic [4:0] SPI_LAST = 5'h0F;
    localparam logic [3:0] SPI_SHIFTS = 4'h7;
    localparam int BAUD_INT_LSB = 6;
    localparam int HI_RXC = 7;
    localparam int HI_OVF = 6;
    localparam int HI_FRAME_ERROR_FLAG = 2;
    localparam int HI_PARITY_ERROR_FLAG = 1;
    localparam int HI_D8 = 0;
    typedef struct packed {
        logic frame_err;
        logic overrun;
        logic parity_err;
        logic [8:0] data;
    } usr_frame_s;
    typedef enum logic [1:0] {
        ASM_IDLE = 2'b00,
        ASM_DATA = 2'b01,
        ASM_PAR = 2'b10,
        ASM_STOP = 2'b11
    } usr_asm_e;
endpackage

// File: dv/usart_rx_errors_sync_spi_host_tb_top.sv
// Self-checking bench for the receive buffer, synchronous clocking and host SPI.
`timescale 1ns/1ps
`default_nettype none
module usart_rx_errors_sync_spi_host_tb_top;
    logic clock = 1'b0, link_clock = 1'b0, nrst = 1'b0, rx_enable = 1'b0;
    logic [1:0] mode_sel = 2'h0, rx_mode = 2'h0, parity_mode = 2'h0;
    logic [2:0] char_size_field = 3'h3;
    logic bit_order_bit = 1'b0, clock_phase_bit = 1'b0, pin_invert_bit = 1'b0, pin_direction_bit = 1'b0;
    logic [15:0] baud_div = 16'h0100;
    logic [7:0] spi_tx_data = 8'h00;
    logic spi_tx_valid = 1'b0, rd_high = 1'b0, rd_low = 1'b0;
    logic spi_tx_ready, tx_pin, tx_oe, xck_out, xck_oe, rx_pin, rx_complete_flag;
    logic [7:0] rx_high_byte_reg, rx_low_byte_reg;
    logic [15:0] notes[$];
    int mismatches = 0, n_checks = 0, cycles = 0, seed = 32'h4bb3;
    initial forever #5 clock = ~clock;
    // The link clock is free running and unrelated in phase to the peripheral clock.
    initial begin
        #13;
        forever #40 link_clock = ~link_clock;
    end
    usr_core dut (.clock(clock), .nrst(nrst), .link_clock(link_clock), .rx_pin(rx_pin), .rx_enable(rx_enable),
        .mode_sel(mode_sel), .rx_mode(rx_mode), .char_size_field(char_size_field), .parity_mode(parity_mode),
        .bit_order_bit(bit_order_bit), .clock_phase_bit(clock_phase_bit), .pin_invert_bit(pin_invert_bit),
        .pin_direction_bit(pin_direction_bit), .baud_div(baud_div), .spi_tx_data(spi_tx_data),
        .spi_tx_valid(spi_tx_valid), .rd_high(rd_high), .rd_low(rd_low), .spi_tx_ready(spi_tx_ready),
        .tx_pin(tx_pin), .tx_oe(tx_oe), .xck_out(xck_out), .xck_oe(xck_oe), .rx_high_byte_reg(rx_high_byte_reg),
        .rx_low_byte_reg(rx_low_byte_reg), .rx_complete_flag(rx_complete_flag));
    usr_peer peer (.link_clock(link_clock), .tx_pin(tx_pin), .tx_oe(tx_oe), .xck_out(xck_out),
        .pin_invert_bit(pin_invert_bit), .clock_phase_bit(clock_phase_bit), .rx_pin(rx_pin));
    // ========
    // Checking
    task automatic check(input logic [15:0] seen, input logic [15:0] want);
        n_checks++;
        if (seen !== want) begin
            mismatches++;
            $display("BAD t=%0t seen %h want %h", $time, seen, want);
        end
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    always @(posedge clock) begin
        cycles++;
        if (cycles == 40000) begin
            mismatches++;
            report_and_stop();
        end
    end
    wire logic shift_rd = (char_size_field == usr_pkg::CS_9L && mode_sel != usr_pkg::MODE_SPI) ? rd_high : rd_low;
    // Each read that advances the buffer is matched against the oldest note.
    always @(posedge clock) begin
        if (shift_rd === 1'b1)
            check({rx_high_byte_reg, rx_low_byte_reg}, notes.size() > 0 ? notes.pop_front() : 16'hXXXX);
    end
    // ========
    // Drivers
    task automatic cfg(input logic [1:0] m, input logic [2:0] cs, input logic [1:0] pm, input logic [1:0] rxm);
        @(posedge clock);
        mode_sel <= m;
        char_size_field <= cs;
        parity_mode <= pm;
        rx_mode <= rxm;
        repeat (4) @(posedge clock);
    endtask
    // The byte that does not advance the buffer is always read first.
    task automatic rd_frame();
        logic lf;
        lf = (char_size_field == usr_pkg::CS_9L);
        @(posedge clock);
        rd_low <= lf;
        rd_high <= !lf;
        @(posedge clock);
        rd_low <= !lf;
        rd_high <= lf;
        @(posedge clock);
        rd_low <= 1'b0;
        rd_high <= 1'b0;
        @(negedge clock);
    endtask
    task automatic rx_frame(input logic [8:0] d, input logic bad_par, input logic bad_stop, input logic ovf, input int bitns);
        logic [11:0] bits;
        logic [7:0] h;
        int nb;
        nb = char_size_field[2] ? 9 : 5 + char_size_field[1:0];
        d = d & (9'h1FF >> (9 - nb));
        bits = 12'hFFF;
        bits[0] = 1'b0;
        for (int i = 0; i < nb; i++)
            bits[i + 1] = d[i];
        if (parity_mode[1])
            bits[nb + 1] = (^d) ^ parity_mode[0] ^ bad_par;
        bits[nb + 1 + parity_mode[1]] = !bad_stop;
        h = 8'h80;
        h[usr_pkg::HI_OVF] = ovf;
        h[usr_pkg::HI_FRAME_ERROR_FLAG] = bad_stop;
        h[usr_pkg::HI_PARITY_ERROR_FLAG] = bad_par;
        h[usr_pkg::HI_D8] = d[8];
        // An overrun replaces the newest stored frame.
        if (ovf)
            void'(notes.pop_back());
        notes.push_back({h, d[7:0]});
        if (bitns > 0)
            peer.send(bits, nb + 2 + parity_mode[1], bitns);
        else
            peer.send_sync(bits, nb + 2 + parity_mode[1]);
    endtask
    task automatic spi_byte(input logic [2:0] opt, input logic [7:0] d);
        logic [7:0] rev;
        int n;
        rev = {<<{d}};
        // Options settle a cycle ahead, so a polarity change never counts as a clock edge at the client.
        @(posedge clock);
        {bit_order_bit, clock_phase_bit, pin_invert_bit} <= opt;
        spi_tx_data <= d;
        @(posedge clock);
        spi_tx_valid <= 1'b1;
        peer.ncap = 0;
        notes.push_back({8'h80, d});
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (spi_tx_ready !== 1'b1 && n < 50);
        spi_tx_valid <= 1'b0;
        for (n = 0; rx_complete_flag !== 1'b1 && n < 300; n++)
            @(posedge clock);
        check({8'h00, peer.cap}, {8'h00, bit_order_bit ? rev : d});
        check(16'(peer.ncap), 16'h0008);
        rd_frame();
    endtask
    // ========
    // Scenarios
    initial begin
        // The first link rising edge falls inside this reset, which the link side carries through its own reset pipe.
        repeat (6) @(posedge clock);
        nrst <= 1'b1;
        @(posedge clock);
        check({14'h0, rx_complete_flag, tx_pin}, 16'h0001);
        rx_enable <= 1'b1;
        for (int pm = 0; pm < 4; pm++) begin
            cfg(usr_pkg::MODE_ASYNC, pm[2:0], pm[1:0], 2'h0);
            for (int k = 0; k < 3; k++) begin
                rx_frame(9'($random(seed)), k == 1 && pm > 1, k == 2, 1'b0, 640);
                rd_frame();
            end
        end
        for (int k = 0; k < 3; k++)
            rx_frame(9'($random(seed)), 1'b0, 1'b0, k == 2, 640);
        for (int k = 0; k < 4 && rx_complete_flag === 1'b1; k++)
            rd_frame();
        check({15'h0, rx_complete_flag}, 16'h0000);
        $display("test parity, framing and overrun done");
        for (int j = 0; j < 2; j++) begin
            cfg(usr_pkg::MODE_ASYNC, j ? usr_pkg::CS_9H : usr_pkg::CS_9L, 2'h0, 2'h0);
            rx_frame(9'($random(seed)), 1'b0, 1'b0, 1'b0, 640);
            rx_frame(9'($random(seed)), 1'b0, 1'b0, 1'b0, 640);
            rd_frame();
            rd_frame();
        end
        cfg(usr_pkg::MODE_ASYNC, 3'h3, usr_pkg::PAR_EVEN, usr_pkg::RXM_DOUBLE);
        rx_frame(9'($random(seed)), 1'b1, 1'b0, 1'b0, 320);
        rd_frame();
        $display("test nine-bit order and double speed done");
        cfg(usr_pkg::MODE_ASYNC, 3'h3, 2'h0, 2'h0);
        rx_frame(9'h0A5, 1'b0, 1'b0, 1'b0, 640);
        notes.delete();
        peer.line = 1'b0;
        #2000;
        @(posedge clock);
        rx_enable <= 1'b0;
        peer.line = 1'b1;
        @(posedge clock);
        @(negedge clock);
        check({15'h0, rx_complete_flag}, 16'h0000);
        @(posedge clock);
        rx_enable <= 1'b1;
        #8000;
        check({15'h0, rx_complete_flag}, 16'h0000);
        $display("test receiver disable done");
        @(posedge clock);
        baud_div <= 16'hFFC0;
        cfg(usr_pkg::MODE_SYNC, 3'h3, 2'h0, 2'h0);
        check({15'h0, xck_oe}, 16'h0000);
        rx_frame(9'($random(seed)), 1'b0, 1'b0, 1'b0, 0);
        rd_frame();
        @(posedge clock);
        pin_direction_bit <= 1'b1;
        baud_div <= 16'h0100;
        @(negedge clock);
        check({15'h0, xck_oe}, 16'h0001);
        $display("test synchronous clocking done");
        cfg(usr_pkg::MODE_SPI, 3'h3, 2'h0, 2'h0);
        for (int i = 0; i < 8; i++)
            spi_byte(i[2:0], 8'($random(seed)));
        check(16'(notes.size()), 16'h0000);
        $display("test host SPI done");
        report_and_stop();
    end
endmodule
`default_nettype wire

// File: dv/usr_peer.sv
// Far-side model: serial sender on the receive pin and an echoing SPI client.
`timescale 1ns/1ps
`default_nettype none
module usr_peer (
    input wire logic link_clock,
    input wire logic tx_pin,
    input wire logic tx_oe,
    input wire logic xck_out,
    input wire logic pin_invert_bit,
    input wire logic clock_phase_bit,
    output logic rx_pin
);
    logic line = 1'b1;
    logic [7:0] cap = 8'h00;
    int ncap = 0;
    wire logic sck = xck_out ^ pin_invert_bit;
    // Host-in echoes host-out, so no client select pin is needed.
    assign rx_pin = tx_oe ? tx_pin : line;
    // The client takes host-out on the edge opposite the host's change edge.
    always @(sck) begin
        if (sck != clock_phase_bit) begin
            cap = {cap[6:0], tx_pin};
            ncap = ncap + 1;
        end
    end
    // Frame bits go out first bit lowest; one idle bit follows so a bad stop is never taken as a start.
    task automatic send(input logic [11:0] bits, input int n, input int bitns);
        for (int i = 0; i < n; i++) begin
            line = bits[i];
            #(bitns);
        end
        line = 1'b1;
        #(bitns);
    endtask
    // Client mode is paced by the external clock alone; bits change on its rising edge.
    task automatic send_sync(input logic [11:0] bits, input int n);
        for (int i = 0; i <= n; i++) begin
            @(posedge link_clock);
            line = (i < n) ? bits[i] : 1'b1;
        end
        repeat (2) @(posedge link_clock);
    endtask
endmodule
`default_nettype wire
